// file: src/msfrx_map.svh
// Register offsets, field reset values and timing counts for the modem flow/receive filter.
// Assumes a 125 MHz core clock and a 32-bit AXI4-Lite register bus.
`ifndef MSFRX_MAP_SVH
`define MSFRX_MAP_SVH

`define MSFRX_OFS_CTRL      8'h00
`define MSFRX_OFS_THRESH    8'h04
`define MSFRX_OFS_GOOD      8'h08
`define MSFRX_OFS_HOP       8'h0c
`define MSFRX_OFS_IDLE      8'h10
`define MSFRX_OFS_WAKE      8'h14
`define MSFRX_OFS_NETID     8'h18
`define MSFRX_OFS_MASK      8'h1c
`define MSFRX_OFS_DEST      8'h20
`define MSFRX_OFS_STATUS    8'h24

`define MSFRX_XON_CHAR      8'h11
`define MSFRX_XOFF_CHAR     8'h13
`define MSFRX_BUF_SIZE      16'h0100
`define MSFRX_THRESH_MARGIN 16'h0011
`define MSFRX_CNT_MAX       16'hffff
`define MSFRX_IDLE_DEF      16'hffff
`define MSFRX_IDLE_NEVER    16'hffff
`define MSFRX_MASK_DEF      16'hffff
`define MSFRX_WAKE_DEF      8'h01
`define MSFRX_HOP_MAX       3'h6
`define MSFRX_PARITY_MAX    3'h4
`define MSFRX_NETID_RO_BIT  15
`define MSFRX_UNIT_MS       100
`define MSFRX_DETECT_MS     35
`define MSFRX_CLK_MHZ       125
`define MSFRX_UNIT_CYC      (`MSFRX_UNIT_MS * 1000 * `MSFRX_CLK_MHZ)
`define MSFRX_DETECT_CYC    (`MSFRX_DETECT_MS * 1000 * `MSFRX_CLK_MHZ)
`define MSFRX_RESP_OKAY     2'h0
`define MSFRX_RESP_SLVERR   2'h2

`endif

// file: src/msfrx_pkg.sv
// Types shared by the modem flow/receive filter.
// Assumes the msfrx_map.svh constants header.
package msfrx_pkg;
	typedef enum logic [2:0] {
		MSFRX_SLP_AWAKE = 3'b001,
		MSFRX_SLP_DOZE  = 3'b010,
		MSFRX_SLP_LISTEN = 3'b100
	} msfrx_slp_t;
	typedef enum logic [2:0] {
		MSFRX_TX_IDLE = 3'b001,
		MSFRX_TX_WAKE = 3'b010,
		MSFRX_TX_PKT  = 3'b100
	} msfrx_tx_t;
endpackage : msfrx_pkg

// file: src/msfrx_tick.sv
// Prescaler giving one-cycle ticks every 100 ms unit.
// Assumes the core clock of the map header.
`timescale 1ns/1ns
`default_nettype none
`include "msfrx_map.svh"
module msfrx_tick #(
	parameter int unsigned UNIT_CYC = `MSFRX_UNIT_CYC
) (
	input  wire logic CORE_CLK,   // Core clock
	input  wire logic RST,        // Synchronous reset
	output logic      TICK        // Unit tick
);
	logic [23:0] cnt_reg;
	logic [23:0] cnt_next;
	logic        tick_reg;
	logic        tick_next;

	always_comb
	begin
		tick_next = (cnt_reg == 24'(UNIT_CYC - 1));
		cnt_next = tick_next ? 24'h000000 : cnt_reg + 24'h000001;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			cnt_reg  <= 24'h000000;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign TICK = tick_reg;
endmodule : msfrx_tick
`default_nettype wire

// file: src/msfrx_top.sv
// Modem serial flow control, receive filter, counters and wake-up timing.
// Assumes AXI4-Lite master, host serial buffer level and radio events as synchronous inputs.
// Overview of operation
// - XON character is 0x11
// - XOFF character is 0x13
// - One-bit software flow enable, reset zero
// - Clear-to-send output gates host transfers
// - At threshold drop CTS or send XOFF
// - Threshold default and max buffer minus 0x11
// - Sixteen-bit good count, writable, reset clears
// - Good count saturates at 0xFFFF
// - Hop channel 0..6, must match to receive
// - After idle time send long wake-up
// - Idle time default 0xFFFF disables long wake
// - Cyclic sleeper wakes per interval, checks initializer
// - Stay awake after 35 ms initializer
// - Wake duration 8-bit, 100 ms units, default 1
// - Drop mismatched network ident; upper ids read-only
// - Transmitted packets carry destination address
// - Accept when masked address matches address or mask
// - Otherwise drop without serial output
// - Mask default 0xFFFF, exact match
// - Parity select 0..4, default 0
// - Power-up mode: idle or command mode
// - Command power-up plus sleep 1: low input wakes
`timescale 1ns/1ns
`default_nettype none
`include "msfrx_map.svh"
module msfrx_top
	import msfrx_pkg::*;
#(
	parameter int unsigned UNIT_CYC   = `MSFRX_UNIT_CYC,
	parameter int unsigned DETECT_CYC = `MSFRX_DETECT_CYC
) (
	input  wire logic        CORE_CLK,        // Core clock
	input  wire logic        RST,             // Synchronous reset
	input  wire logic [7:0]  S_AXI_AWADDR,    // Write address
	input  wire logic        S_AXI_AWVALID,   // Write address valid
	output logic             S_AXI_AWREADY,   // Write address ready
	input  wire logic [31:0] S_AXI_WDATA,     // Write data
	input  wire logic [3:0]  S_AXI_WSTRB,     // Write strobes
	input  wire logic        S_AXI_WVALID,    // Write data valid
	output logic             S_AXI_WREADY,    // Write data ready
	output logic [1:0]       S_AXI_BRESP,     // Write response
	output logic             S_AXI_BVALID,    // Write response valid
	input  wire logic        S_AXI_BREADY,    // Write response ready
	input  wire logic [7:0]  S_AXI_ARADDR,    // Read address
	input  wire logic        S_AXI_ARVALID,   // Read address valid
	output logic             S_AXI_ARREADY,   // Read address ready
	output logic [31:0]      S_AXI_RDATA,     // Read data
	output logic [1:0]       S_AXI_RRESP,     // Read response
	output logic             S_AXI_RVALID,    // Read data valid
	input  wire logic        S_AXI_RREADY,    // Read data ready
	input  wire logic [15:0] SERIAL_INPUT_LEVEL, // Bytes held in serial input buffer
	output logic             SECOND_DIGITAL_OUTPUT, // Clear-to-send, high allows host
	output logic [7:0]       FLOW_CHAR,       // XON/XOFF character to host
	output logic             FLOW_CHAR_VALID, // Character offered
	input  wire logic        FLOW_CHAR_READY, // Serial output took character
	input  wire logic        RX_PKT_VALID,    // Received good packet pulse
	input  wire logic [2:0]  RX_PKT_HOP,      // Packet hop channel
	input  wire logic [15:0] RX_PKT_IDENT,    // Packet network identifier
	input  wire logic [15:0] RX_PKT_ADDR,     // Packet destination address
	output logic             RX_FORWARD,      // Packet forwarded to serial output
	output logic             RX_DROP,         // Packet discarded
	input  wire logic        TX_REQ,          // Packet ready to transmit
	output logic             TX_WAKE_ON,      // Sending wake-up initializer
	output logic             TX_PKT_GO,       // Start packet transmit pulse
	output logic [15:0]      TX_PKT_ADDR,     // Address carried by packet
	input  wire logic        RX_ACTIVITY,     // Radio receive activity
	input  wire logic        CYCLIC_SLEEP,    // Cyclic sleep enabled
	input  wire logic [7:0]  SLEEP_INTERVAL,  // Cyclic sleep interval, 100 ms units
	input  wire logic        WAKE_INIT_SEEN,  // Initializer carrier present
	output logic             RX_AWAKE,        // Receiver powered
	input  wire logic        THIRD_DIGITAL_INPUT, // Host wake line, low wakes
	output logic             CMD_MODE,        // Device in command mode
	output logic [2:0]       PARITY_SELECT    // Serial parity mode
);
	logic tick;

	// Config registers
	logic        sw_flow_enable_reg, sw_flow_enable_next;
	logic        powerup_cmd_mode_reg, powerup_cmd_mode_next;
	logic        sleep_select_reg, sleep_select_next;
	logic [2:0]  parity_select_reg, parity_select_next;
	logic [15:0] flow_threshold_reg, flow_threshold_next;
	logic [15:0] good_packet_count_reg, good_packet_count_next;
	logic [2:0]  hop_channel_reg, hop_channel_next;
	logic [15:0] long_init_idle_time_reg, long_init_idle_time_next;
	logic [7:0]  wake_init_duration_reg, wake_init_duration_next;
	logic [15:0] network_ident_reg, network_ident_next;
	logic [15:0] addr_mask_reg, addr_mask_next;
	logic [15:0] dest_addr_reg, dest_addr_next;
	// Bus state
	logic        aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
	logic [7:0]  awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic        wstrb0_reg, wstrb0_next;
	logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        wr_go, wr_hit, rd_hit;
	logic [15:0] thr_max;
	// Flow, filter, wake state
	logic        cts_reg, cts_next, stopped_reg, stopped_next;
	logic        char_pend_reg, char_pend_next;
	logic [7:0]  char_reg, char_next;
	logic        fwd_reg, fwd_next, drop_reg, drop_next, accept;
	logic [15:0] masked;
	msfrx_tx_t   tx_reg, tx_next;
	logic [15:0] idle_reg, idle_next;
	logic [7:0]  wake_cnt_reg, wake_cnt_next;
	logic        go_reg, go_next;
	msfrx_slp_t  slp_reg, slp_next;
	logic [7:0]  slp_cnt_reg, slp_cnt_next;
	logic [31:0] det_reg, det_next;
	logic        cmd_reg, cmd_next;

	msfrx_tick #(.UNIT_CYC(UNIT_CYC)) u_tick (
		.CORE_CLK (CORE_CLK),
		.RST      (RST),
		.TICK     (tick)
	);

	assign thr_max = `MSFRX_BUF_SIZE - `MSFRX_THRESH_MARGIN;
	assign wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;

	always_comb
	begin
		aw_hold_next = aw_hold_reg;
		w_hold_next = w_hold_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb0_next = wstrb0_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		wr_hit = 1'b1;
		rd_hit = 1'b1;
		if (S_AXI_AWVALID && !aw_hold_reg)
		begin
			aw_hold_next = 1'b1;
			awaddr_next = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !w_hold_reg)
		begin
			w_hold_next = 1'b1;
			wdata_next = S_AXI_WDATA;
			// Strobe is only valid with WVALID, so keep it with the data
			wstrb0_next = S_AXI_WSTRB[0];
		end
		if (wr_go)
		begin
			unique case (awaddr_reg)
				`MSFRX_OFS_CTRL, `MSFRX_OFS_THRESH, `MSFRX_OFS_GOOD, `MSFRX_OFS_HOP,
				`MSFRX_OFS_IDLE, `MSFRX_OFS_WAKE, `MSFRX_OFS_NETID, `MSFRX_OFS_MASK,
				`MSFRX_OFS_DEST, `MSFRX_OFS_STATUS: wr_hit = 1'b1;
				default: wr_hit = 1'b0;
			endcase
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wr_hit ? `MSFRX_RESP_OKAY : `MSFRX_RESP_SLVERR;
		end
		else if (bvalid_reg && S_AXI_BREADY)
			bvalid_next = 1'b0;
		if (rvalid_reg && S_AXI_RREADY)
			rvalid_next = 1'b0;
		else if (S_AXI_ARVALID && !rvalid_reg)
		begin
			rvalid_next = 1'b1;
			rdata_next = 32'h00000000;
			unique case (S_AXI_ARADDR)
				`MSFRX_OFS_CTRL: rdata_next = {26'h0000000, parity_select_reg,
					sleep_select_reg, powerup_cmd_mode_reg, sw_flow_enable_reg};
				`MSFRX_OFS_THRESH: rdata_next = {16'h0000, flow_threshold_reg};
				`MSFRX_OFS_GOOD:   rdata_next = {16'h0000, good_packet_count_reg};
				`MSFRX_OFS_HOP:    rdata_next = {29'h00000000, hop_channel_reg};
				`MSFRX_OFS_IDLE:   rdata_next = {16'h0000, long_init_idle_time_reg};
				`MSFRX_OFS_WAKE:   rdata_next = {24'h000000, wake_init_duration_reg};
				`MSFRX_OFS_NETID:  rdata_next = {16'h0000, network_ident_reg};
				`MSFRX_OFS_MASK:   rdata_next = {16'h0000, addr_mask_reg};
				`MSFRX_OFS_DEST:   rdata_next = {16'h0000, dest_addr_reg};
				`MSFRX_OFS_STATUS: rdata_next = {26'h0000000, cmd_reg, RX_AWAKE,
					tx_reg == MSFRX_TX_WAKE, stopped_reg, cts_reg, char_pend_reg};
				default: rd_hit = 1'b0;
			endcase
			rresp_next = rd_hit ? `MSFRX_RESP_OKAY : `MSFRX_RESP_SLVERR;
		end
	end

	// Register writes; low byte lane gates the whole field for simplicity
	always_comb
	begin
		sw_flow_enable_next = sw_flow_enable_reg;
		powerup_cmd_mode_next = powerup_cmd_mode_reg;
		sleep_select_next = sleep_select_reg;
		parity_select_next = parity_select_reg;
		flow_threshold_next = flow_threshold_reg;
		hop_channel_next = hop_channel_reg;
		long_init_idle_time_next = long_init_idle_time_reg;
		wake_init_duration_next = wake_init_duration_reg;
		network_ident_next = network_ident_reg;
		addr_mask_next = addr_mask_reg;
		dest_addr_next = dest_addr_reg;
		good_packet_count_next = good_packet_count_reg;
		if (accept && good_packet_count_reg != `MSFRX_CNT_MAX)
			good_packet_count_next = good_packet_count_reg + 16'h0001;
		if (wr_go && wstrb0_reg)
		begin
			unique case (awaddr_reg)
				`MSFRX_OFS_CTRL:
				begin
					sw_flow_enable_next = wdata_reg[0];
					powerup_cmd_mode_next = wdata_reg[1];
					sleep_select_next = wdata_reg[2];
					if (wdata_reg[5:3] <= `MSFRX_PARITY_MAX)
						parity_select_next = wdata_reg[5:3];
				end
				`MSFRX_OFS_THRESH:
					if (wdata_reg[31:16] == 16'h0000 && wdata_reg[15:0] <= thr_max)
						flow_threshold_next = wdata_reg[15:0];
				`MSFRX_OFS_GOOD: good_packet_count_next = wdata_reg[15:0];
				`MSFRX_OFS_HOP:
					if (wdata_reg[31:3] == 29'h00000000 && wdata_reg[2:0] <= `MSFRX_HOP_MAX)
						hop_channel_next = wdata_reg[2:0];
				`MSFRX_OFS_IDLE: long_init_idle_time_next = wdata_reg[15:0];
				`MSFRX_OFS_WAKE: wake_init_duration_next = wdata_reg[7:0];
				`MSFRX_OFS_NETID:
					if (!wdata_reg[`MSFRX_NETID_RO_BIT] && !network_ident_reg[`MSFRX_NETID_RO_BIT])
						network_ident_next = wdata_reg[15:0];
				`MSFRX_OFS_MASK: addr_mask_next = wdata_reg[15:0];
				`MSFRX_OFS_DEST: dest_addr_next = wdata_reg[15:0];
				default: ;
			endcase
		end
	end

	assign masked = RX_PKT_ADDR & addr_mask_reg;
	assign accept = RX_PKT_VALID && RX_PKT_HOP == hop_channel_reg
		&& RX_PKT_IDENT == network_ident_reg
		&& (masked == dest_addr_reg || masked == addr_mask_reg);

	always_comb
	begin
		cts_next = cts_reg;
		stopped_next = stopped_reg;
		char_pend_next = char_pend_reg;
		char_next = char_reg;
		fwd_next = accept;
		drop_next = RX_PKT_VALID && !accept;
		if (char_pend_reg && FLOW_CHAR_READY)
			char_pend_next = 1'b0;
		if (SERIAL_INPUT_LEVEL >= flow_threshold_reg)
		begin
			cts_next = 1'b0;
			if (sw_flow_enable_reg && !stopped_reg && !char_pend_reg)
			begin
				stopped_next = 1'b1;
				char_pend_next = 1'b1;
				char_next = `MSFRX_XOFF_CHAR;
			end
		end
		else
		begin
			cts_next = 1'b1;
			if (stopped_reg && !char_pend_reg)
			begin
				stopped_next = 1'b0;
				char_pend_next = 1'b1;
				char_next = `MSFRX_XON_CHAR;
			end
		end
	end

	always_comb
	begin
		tx_next = tx_reg;
		idle_next = idle_reg;
		wake_cnt_next = wake_cnt_reg;
		go_next = 1'b0;
		if (RX_ACTIVITY || tx_reg != MSFRX_TX_IDLE)
			idle_next = 16'h0000;
		else if (tick && idle_reg != `MSFRX_CNT_MAX)
			idle_next = idle_reg + 16'h0001;
		unique case (tx_reg)
			MSFRX_TX_IDLE:
				if (TX_REQ)
				begin
					if (long_init_idle_time_reg != `MSFRX_IDLE_NEVER
						&& idle_reg >= long_init_idle_time_reg
						&& wake_init_duration_reg != 8'h00)
					begin
						tx_next = MSFRX_TX_WAKE;
						wake_cnt_next = wake_init_duration_reg;
					end
					else
						tx_next = MSFRX_TX_PKT;
				end
			MSFRX_TX_WAKE:
			begin
				if (tick)
					wake_cnt_next = wake_cnt_reg - 8'h01;
				if (tick && wake_cnt_reg == 8'h01)
					tx_next = MSFRX_TX_PKT;
			end
			MSFRX_TX_PKT:
			begin
				go_next = 1'b1;
				tx_next = MSFRX_TX_IDLE;
			end
		endcase
	end

	always_comb
	begin
		slp_next = slp_reg;
		slp_cnt_next = slp_cnt_reg;
		det_next = WAKE_INIT_SEEN ? det_reg + 32'h00000001 : 32'h00000000;
		cmd_next = cmd_reg;
		if (powerup_cmd_mode_reg && sleep_select_reg && !THIRD_DIGITAL_INPUT)
			cmd_next = 1'b1;
		unique case (slp_reg)
			MSFRX_SLP_AWAKE:
				// Stay up while an initializer or data is still arriving
				if (CYCLIC_SLEEP && !cmd_next && !WAKE_INIT_SEEN && !RX_ACTIVITY)
				begin
					slp_next = MSFRX_SLP_DOZE;
					slp_cnt_next = SLEEP_INTERVAL;
				end
			MSFRX_SLP_DOZE:
				if (cmd_next || !CYCLIC_SLEEP)
					slp_next = MSFRX_SLP_AWAKE;
				else if (tick)
				begin
					slp_cnt_next = slp_cnt_reg - 8'h01;
					if (slp_cnt_reg <= 8'h01)
					begin
						slp_next = MSFRX_SLP_LISTEN;
						slp_cnt_next = 8'h01;
					end
				end
			MSFRX_SLP_LISTEN:
				if (det_reg >= 32'(DETECT_CYC) || cmd_next)
					slp_next = MSFRX_SLP_AWAKE;
				else if (tick)
				begin
					slp_next = MSFRX_SLP_DOZE;
					slp_cnt_next = SLEEP_INTERVAL;
				end
		endcase
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			sw_flow_enable_reg <= 1'b0;
			powerup_cmd_mode_reg <= 1'b0;
			sleep_select_reg <= 1'b0;
			parity_select_reg <= 3'h0;
			flow_threshold_reg <= `MSFRX_BUF_SIZE - `MSFRX_THRESH_MARGIN;
			good_packet_count_reg <= 16'h0000;
			hop_channel_reg <= 3'h0;
			long_init_idle_time_reg <= `MSFRX_IDLE_DEF;
			wake_init_duration_reg <= `MSFRX_WAKE_DEF;
			network_ident_reg <= 16'h0000;
			addr_mask_reg <= `MSFRX_MASK_DEF;
			dest_addr_reg <= 16'h0000;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `MSFRX_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= `MSFRX_RESP_OKAY;
			rdata_reg <= 32'h00000000;
			cts_reg <= 1'b0;
			stopped_reg <= 1'b0;
			char_pend_reg <= 1'b0;
			char_reg <= 8'h00;
			fwd_reg <= 1'b0;
			drop_reg <= 1'b0;
			tx_reg <= MSFRX_TX_IDLE;
			idle_reg <= 16'h0000;
			wake_cnt_reg <= 8'h00;
			go_reg <= 1'b0;
			slp_reg <= MSFRX_SLP_AWAKE;
			slp_cnt_reg <= 8'h00;
			det_reg <= 32'h00000000;
			cmd_reg <= 1'b0;
		end
		else
		begin
			sw_flow_enable_reg <= sw_flow_enable_next;
			powerup_cmd_mode_reg <= powerup_cmd_mode_next;
			sleep_select_reg <= sleep_select_next;
			parity_select_reg <= parity_select_next;
			flow_threshold_reg <= flow_threshold_next;
			good_packet_count_reg <= good_packet_count_next;
			hop_channel_reg <= hop_channel_next;
			long_init_idle_time_reg <= long_init_idle_time_next;
			wake_init_duration_reg <= wake_init_duration_next;
			network_ident_reg <= network_ident_next;
			addr_mask_reg <= addr_mask_next;
			dest_addr_reg <= dest_addr_next;
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb0_reg <= wstrb0_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			cts_reg <= cts_next;
			stopped_reg <= stopped_next;
			char_pend_reg <= char_pend_next;
			char_reg <= char_next;
			fwd_reg <= fwd_next;
			drop_reg <= drop_next;
			tx_reg <= tx_next;
			idle_reg <= idle_next;
			wake_cnt_reg <= wake_cnt_next;
			go_reg <= go_next;
			slp_reg <= slp_next;
			slp_cnt_reg <= slp_cnt_next;
			det_reg <= det_next;
			cmd_reg <= cmd_next;
		end
	end

	// command mode follows the power-up setting bit at all times, or the wake latched from the host line
	assign CMD_MODE = cmd_reg || powerup_cmd_mode_reg;
	assign S_AXI_AWREADY = !aw_hold_reg;
	assign S_AXI_WREADY = !w_hold_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;
	assign S_AXI_ARREADY = !rvalid_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;
	assign SECOND_DIGITAL_OUTPUT = cts_reg;
	assign FLOW_CHAR = char_reg;
	assign FLOW_CHAR_VALID = char_pend_reg;
	assign RX_FORWARD = fwd_reg;
	assign RX_DROP = drop_reg;
	assign TX_WAKE_ON = (tx_reg == MSFRX_TX_WAKE);
	assign TX_PKT_GO = go_reg;
	assign TX_PKT_ADDR = dest_addr_reg;
	assign RX_AWAKE = (slp_reg != MSFRX_SLP_DOZE);
	assign PARITY_SELECT = parity_select_reg;

	cts_drop_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		!RST && SERIAL_INPUT_LEVEL >= flow_threshold_reg |=> !SECOND_DIGITAL_OUTPUT)
		else $error("clear-to-send high above threshold");
	cts_back_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		// Sampled reset term skips the edge where CTS is still held low by reset
		!RST && SERIAL_INPUT_LEVEL < flow_threshold_reg |=> SECOND_DIGITAL_OUTPUT)
		else $error("clear-to-send low below threshold");
	flow_char_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		FLOW_CHAR_VALID |-> FLOW_CHAR == (stopped_reg ? 8'h13 : 8'h11))
		else $error("wrong flow character");
	good_sat_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		good_packet_count_reg == 16'hffff && !wr_go |=> good_packet_count_reg == 16'hffff)
		else $error("good count wrapped");
	good_inc_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		accept && !wr_go && good_packet_count_reg != 16'hffff
		|=> good_packet_count_reg == $past(good_packet_count_reg) + 16'h0001)
		else $error("good count missed packet");
	rx_filter_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		RX_PKT_VALID |=> (RX_FORWARD ^ RX_DROP))
		else $error("packet neither forwarded nor dropped");
	hop_drop_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		RX_PKT_VALID && RX_PKT_HOP != hop_channel_reg |=> RX_DROP)
		else $error("foreign channel accepted");
	// never sends long initializer when disabled
	wake_off_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		long_init_idle_time_reg == 16'hffff && tx_reg == MSFRX_TX_IDLE |=> !TX_WAKE_ON)
		else $error("long initializer sent while disabled");
	tx_addr_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		tx_reg == MSFRX_TX_PKT |=> TX_PKT_GO && TX_PKT_ADDR == $past(dest_addr_reg))
		else $error("packet address wrong");
endmodule : msfrx_top
`default_nettype wire

// file: verification/msfrx_host.sv
// Host controller model on the modem serial side.
// Assumes the bench sets a fill target; the level moves one byte a cycle.
`timescale 1ns/1ns
`default_nettype none
module msfrx_host (
	input  wire logic        clk,          // Core clock
	input  wire logic        cts,          // Clear-to-send
	input  wire logic [7:0]  chr,          // Flow character
	input  wire logic        chr_valid,    // Character offered
	input  wire logic [15:0] target,       // Fill level aimed at
	input  wire logic        slow,         // Take characters every other cycle
	output var  logic [15:0] level = 0,    // Device input buffer level
	output var  logic        ready = 0,    // Character taken
	output var  logic        stopped = 0,  // Halted by stop character
	output var  logic [7:0]  last_chr = 0  // Last character taken
);
	always @(posedge clk)
	begin
		ready <= slow ? !ready : 1'b1;
		if (chr_valid && ready)
		begin
			last_chr <= chr;
			stopped <= chr == 8'h13;
		end
		if (level > target)
			level <= level - 16'h1;
		else if (level < target && cts && !stopped)
			level <= level + 16'h1;
	end
endmodule : msfrx_host
`default_nettype wire

// file: verification/test_modem_serial_flow_rx_filter.sv
// Bench for the modem flow control and receive filter.
// Assumes msfrx_top with short tick counts and the host model.
`timescale 1ns/1ns
`default_nettype none
`include "msfrx_map.svh"
module test_modem_serial_flow_rx_filter;
	logic CORE_CLK=0, RST=1, S_AXI_AWVALID=0, S_AXI_WVALID=0, S_AXI_BREADY=0;
	logic S_AXI_ARVALID=0, S_AXI_RREADY=0, RX_PKT_VALID=0, TX_REQ=0, RX_ACTIVITY=0;
	logic CYCLIC_SLEEP=0, WAKE_INIT_SEEN=0, THIRD_DIGITAL_INPUT=1, FLOW_CHAR_READY;
	logic SECOND_DIGITAL_OUTPUT, FLOW_CHAR_VALID, RX_FORWARD, RX_DROP, TX_WAKE_ON;
	logic TX_PKT_GO, RX_AWAKE, CMD_MODE, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
	logic S_AXI_ARREADY, S_AXI_RVALID, slow=0, stopped;
	logic [7:0]  S_AXI_AWADDR=0, S_AXI_ARADDR=0, SLEEP_INTERVAL=2, FLOW_CHAR, last_chr;
	logic [31:0] S_AXI_WDATA=0, S_AXI_RDATA, d;
	logic [3:0]  S_AXI_WSTRB=4'hf;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
	logic [15:0] SERIAL_INPUT_LEVEL, RX_PKT_IDENT=0, RX_PKT_ADDR=0, TX_PKT_ADDR, target=0;
	logic [2:0]  RX_PKT_HOP=0, PARITY_SELECT;
	logic [7:0]  ra[7] = '{`MSFRX_OFS_CTRL, `MSFRX_OFS_THRESH, `MSFRX_OFS_GOOD,
		`MSFRX_OFS_HOP, `MSFRX_OFS_IDLE, `MSFRX_OFS_WAKE, `MSFRX_OFS_MASK};
	logic [31:0] rv[7] = '{32'h0, 32'(`MSFRX_BUF_SIZE - `MSFRX_THRESH_MARGIN), 32'h0,
		32'h0, 32'hffff, 32'h1, 32'hffff};
	int          fail_count = 0;
	int          n_checks = 0;
	int          i;
	msfrx_top #(.UNIT_CYC(10), .DETECT_CYC(4)) dut (.*);
	msfrx_host host (.clk(CORE_CLK), .cts(SECOND_DIGITAL_OUTPUT), .chr(FLOW_CHAR),
		.chr_valid(FLOW_CHAR_VALID), .target(target), .slow(slow),
		.level(SERIAL_INPUT_LEVEL), .ready(FLOW_CHAR_READY), .stopped(stopped),
		.last_chr(last_chr));
	always #4 CORE_CLK = !CORE_CLK;
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task summarize;
		if (fail_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	// Readiness is sampled at the falling edge, where nothing moves
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w, b;
		@(posedge CORE_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= v;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do
		begin
			@(negedge CORE_CLK);
			aw = S_AXI_AWVALID && S_AXI_AWREADY;
			w = S_AXI_WVALID && S_AXI_WREADY;
			b = S_AXI_BVALID;
			r = S_AXI_BRESP;
			@(posedge CORE_CLK);
			if (aw)
				S_AXI_AWVALID <= 1'b0;
			if (w)
				S_AXI_WVALID <= 1'b0;
		end
		while (!b);
		S_AXI_BREADY <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [7:0] a);
		logic t, v;
		@(posedge CORE_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do
		begin
			@(negedge CORE_CLK);
			t = S_AXI_ARVALID && S_AXI_ARREADY;
			v = S_AXI_RVALID;
			d = S_AXI_RDATA;
			r = S_AXI_RRESP;
			@(posedge CORE_CLK);
			if (t)
				S_AXI_ARVALID <= 1'b0;
		end
		while (!v);
		S_AXI_RREADY <= 1'b0;
		#1;
	endtask : rd
	task rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask : rc
	task pk(input logic [2:0] h, input logic [15:0] id, a, input logic f);
		@(posedge CORE_CLK);
		RX_PKT_HOP <= h;
		RX_PKT_IDENT <= id;
		RX_PKT_ADDR <= a;
		RX_PKT_VALID <= 1'b1;
		@(posedge CORE_CLK);
		RX_PKT_VALID <= 1'b0;
		#1;
		chk(32'({RX_FORWARD, RX_DROP}), 32'({f, !f}));
	endtask : pk
	task tx(input logic e);
		logic w;
		w = 0;
		@(posedge CORE_CLK);
		TX_REQ <= 1'b1;
		for (i = 0; i < 500 && !TX_PKT_GO; i++)
		begin
			@(posedge CORE_CLK);
			#1 w |= TX_WAKE_ON;
		end
		TX_REQ <= 1'b0;
		chk(32'(w), 32'(e));
		chk(32'(TX_PKT_ADDR), 32'h1200);
	endtask : tx
	initial
	begin
		#300000 fail_count++;
		summarize;
	end
	initial
	begin
		repeat (12) @(posedge CORE_CLK);
		RST <= 1'b0;
		for (int k = 0; k < 7; k++)
			rc(ra[k], rv[k]);
		rd(8'h40);
		chk(32'(r), 32'h2);
		wr(8'h40, 32'h0);
		chk(32'(r), 32'h2);
		wr(`MSFRX_OFS_THRESH, 32'hf0);
		chk(32'(r), 32'h0);
		rc(`MSFRX_OFS_THRESH, 32'hef);
		wr(`MSFRX_OFS_HOP, 32'h7);
		rc(`MSFRX_OFS_HOP, 32'h0);
		wr(`MSFRX_OFS_NETID, 32'h8001);
		rc(`MSFRX_OFS_NETID, 32'h0);
		for (int p = 0; p < 6; p++)
		begin
			wr(`MSFRX_OFS_CTRL, 32'(p) << 3);
			chk(32'(PARITY_SELECT), p < 5 ? 32'(p) : 32'h4);
		end
		wr(`MSFRX_OFS_THRESH, 32'h20);
		wr(`MSFRX_OFS_CTRL, 32'h1);
		slow <= 1'b1;
		target <= 16'h40;
		for (i = 0; i < 400 && !stopped; i++)
			@(posedge CORE_CLK);
		#1 chk(32'(last_chr), 32'(`MSFRX_XOFF_CHAR));
		chk(32'(SECOND_DIGITAL_OUTPUT), 32'h0);
		target <= 16'h0;
		for (i = 0; i < 400 && stopped; i++)
			@(posedge CORE_CLK);
		#1 chk(32'(last_chr), 32'(`MSFRX_XON_CHAR));
		chk(32'(SECOND_DIGITAL_OUTPUT), 32'h1);
		wr(`MSFRX_OFS_HOP, 32'h2);
		wr(`MSFRX_OFS_NETID, 32'h5);
		wr(`MSFRX_OFS_DEST, 32'h1200);
		wr(`MSFRX_OFS_MASK, 32'hff00);
		pk(3'h2, 16'h5, 16'h12ab, 1'b1);
		pk(3'h2, 16'h5, 16'hff55, 1'b1);
		pk(3'h2, 16'h5, 16'h3400, 1'b0);
		pk(3'h3, 16'h5, 16'h1200, 1'b0);
		pk(3'h2, 16'h6, 16'h1200, 1'b0);
		wr(`MSFRX_OFS_GOOD, 32'hfffe);
		repeat (3) pk(3'h2, 16'h5, 16'h1200, 1'b1);
		rc(`MSFRX_OFS_GOOD, 32'hffff);
		tx(1'b0);
		wr(`MSFRX_OFS_IDLE, 32'h1);
		wr(`MSFRX_OFS_WAKE, 32'h3);
		repeat (40) @(posedge CORE_CLK);
		tx(1'b1);
		// Cyclic sleep: doze, then held awake by a long initializer
		@(posedge CORE_CLK);
		CYCLIC_SLEEP <= 1'b1;
		repeat (3) @(posedge CORE_CLK);
		WAKE_INIT_SEEN <= 1'b1;
		#1 chk(32'(RX_AWAKE), 32'h0);
		repeat (40) @(posedge CORE_CLK);
		WAKE_INIT_SEEN <= 1'b0;
		#1 chk(32'(RX_AWAKE), 32'h1);
		repeat (2) @(posedge CORE_CLK);
		CYCLIC_SLEEP <= 1'b0;
		#1 chk(32'(RX_AWAKE), 32'h0);
		wr(`MSFRX_OFS_CTRL, 32'h6);
		chk(32'(CMD_MODE), 32'h1);
		@(posedge CORE_CLK);
		THIRD_DIGITAL_INPUT <= 1'b0;
		wr(`MSFRX_OFS_CTRL, 32'h0);
		chk(32'(CMD_MODE), 32'h1);
		rc(`MSFRX_OFS_STATUS, 32'h32);
		// Mid-run reset clears the count and the command latch
		@(posedge CORE_CLK);
		RST <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		RST <= 1'b0;
		rc(`MSFRX_OFS_GOOD, 32'h0);
		chk(32'(CMD_MODE), 32'h0);
		summarize;
	end
endmodule : test_modem_serial_flow_rx_filter
`default_nettype wire
